/* File: rtl/tioscc_top.sv */
`timescale 1ns/1ps
// Function
// - field all zeros is compare with pin output off; this is the reset value.
// - compare mode: bit 2 gives initial level; low bits 01 drive 0 on match.
// - compare mode low bits 10 drive pin to 1 on each match after the entry cycle.
// - low bits 11 toggle on match; 00 with bit 2 set keeps output off.
// - bit 3 set, low 00 captures on rising pin edge; channel 2 ignores bit 2.
// - capture mode low bits 01 capture on falling pin edge.
// - capture mode with bit 1 set captures on both pin edges.
// - channel 3 A with bits 3 and 2 set captures on channel 4 counting.
// - channel 4 source captures whenever channel 4 counter counts up or down.
// - channel 3 C pin capture uses its own C pin.
// - with buffer mode on, the C field has no effect and makes no events.
module tioscc_top
	import tioscc_pkg::*;
#(
	parameter int W = tioscc_pkg::CNT_W
)
(
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	input  wire logic [tioscc_pkg::FIELD_W-1:0] chan2_a_field,
	input  wire logic [tioscc_pkg::FIELD_W-1:0] chan3_a_field,
	input  wire logic [tioscc_pkg::FIELD_W-1:0] chan3_c_field,
	input  wire logic                          buffer_a_enable,
	input  wire logic                          chan2_match_a,
	input  wire logic                          chan3_match_a,
	input  wire logic                          chan3_match_c,
	input  wire logic                          chan2_pin_a_in,
	input  wire logic                          chan3_pin_a_in,
	input  wire logic                          chan3_pin_c_in,
	input  wire logic                          chan4_count_up,
	input  wire logic                          chan4_count_down,
	input  wire logic [W-1:0]                  chan2_counter,
	input  wire logic [W-1:0]                  chan3_counter,
	output logic                               chan2_pin_a_out,
	output logic                               chan2_pin_a_oe_n,
	output logic                               chan3_pin_a_out,
	output logic                               chan3_pin_a_oe_n,
	output logic                               chan3_pin_c_out,
	output logic                               chan3_pin_c_oe_n,
	output logic [W-1:0]                       chan2_general_reg_a,
	output logic [W-1:0]                       chan3_general_reg_a,
	output logic [W-1:0]                       chan3_general_reg_c,
	output logic [NUM_UNITS-1:0]               capture_pulse
);
	// ****************************************
	// per-unit wiring
	// ****************************************
	// channel 4 activity: either direction counts as one event
	wire logic ch4_evt_w = chan4_count_up || chan4_count_down;

	wire logic [FIELD_W-1:0] field_w   [NUM_UNITS];
	wire logic               inhibit_w [NUM_UNITS];
	wire logic               match_w   [NUM_UNITS];
	wire logic               pin_in_w  [NUM_UNITS];
	wire logic [W-1:0]       cnt_w     [NUM_UNITS];
	wire logic               pout_w    [NUM_UNITS];
	wire logic               poe_w     [NUM_UNITS];
	wire logic [W-1:0]       greg_w    [NUM_UNITS];

	// channel 2 A sees no channel 4 source, so its bit 2 is a don't-care in capture
	assign field_w[UNIT_CH2A]   = chan2_a_field;
	assign field_w[UNIT_CH3A]   = chan3_a_field;
	assign field_w[UNIT_CH3C]   = chan3_c_field;
	assign inhibit_w[UNIT_CH2A] = 1'b0;
	assign inhibit_w[UNIT_CH3A] = 1'b0;
	assign inhibit_w[UNIT_CH3C] = buffer_a_enable;
	assign match_w[UNIT_CH2A]   = chan2_match_a;
	assign match_w[UNIT_CH3A]   = chan3_match_a;
	assign match_w[UNIT_CH3C]   = chan3_match_c;
	assign pin_in_w[UNIT_CH2A]  = chan2_pin_a_in;
	assign pin_in_w[UNIT_CH3A]  = chan3_pin_a_in;
	assign pin_in_w[UNIT_CH3C]  = chan3_pin_c_in;
	assign cnt_w[UNIT_CH2A]     = chan2_counter;
	assign cnt_w[UNIT_CH3A]     = chan3_counter;
	assign cnt_w[UNIT_CH3C]     = chan3_counter;

	// ****************************************
	// unit instances
	// ****************************************
	// all outputs leave straight from flip-flops inside each unit
	genvar u;
	generate
		for (u = 0; u < NUM_UNITS; u++)
		begin : g_unit
			tioscc_unit #(
				.W          (W),
				.CH4_SOURCE (u != UNIT_CH2A)
			) u_unit (
				.clk             (clk),
				.rst_n           (rst_n),
				.field           (field_w[u]),
				.inhibit         (inhibit_w[u]),
				.compare_match   (match_w[u]),
				.pin_in          (pin_in_w[u]),
				.ch4_count_event (ch4_evt_w),
				.counter         (cnt_w[u]),
				.pin_out         (pout_w[u]),
				.pin_oe_n        (poe_w[u]),
				.general_reg     (greg_w[u]),
				.capture_event   (capture_pulse[u])
			);
		end
	endgenerate

	// ****************************************
	// outputs
	// ****************************************
	assign chan2_pin_a_out     = pout_w[UNIT_CH2A];
	assign chan2_pin_a_oe_n    = poe_w[UNIT_CH2A];
	assign chan3_pin_a_out     = pout_w[UNIT_CH3A];
	assign chan3_pin_a_oe_n    = poe_w[UNIT_CH3A];
	assign chan3_pin_c_out     = pout_w[UNIT_CH3C];
	assign chan3_pin_c_oe_n    = poe_w[UNIT_CH3C];
	assign chan2_general_reg_a = greg_w[UNIT_CH2A];
	assign chan3_general_reg_a = greg_w[UNIT_CH3A];
	assign chan3_general_reg_c = greg_w[UNIT_CH3C];
endmodule : tioscc_top

/* File: rtl/tioscc_pkg.sv */
package tioscc_pkg;
	// ****************************************
	// field layout of a 4-bit I/O control field
	// ****************************************
	localparam int          FIELD_W       = 4;
	localparam int          BIT_CAPTURE   = 3;
	localparam int          BIT_LEVEL_SRC = 2;
	localparam int          BIT_ACT_HI    = 1;
	localparam int          BIT_ACT_LO    = 0;
	localparam logic [3:0]  FIELD_RESET   = 4'h0;
	localparam logic [1:0]  ACT_NONE      = 2'h0;
	localparam logic [1:0]  ACT_DRIVE0    = 2'h1;
	localparam logic [1:0]  ACT_DRIVE1    = 2'h2;
	localparam logic [1:0]  ACT_TOGGLE    = 2'h3;
	localparam int          CNT_W         = 16;
	localparam int          NUM_UNITS     = 3;
	localparam int          UNIT_CH2A     = 0;
	localparam int          UNIT_CH3A     = 1;
	localparam int          UNIT_CH3C     = 2;

	// decoded behaviour of one field
	typedef enum {TIOSCC_CMP_OFF, TIOSCC_CMP_OUT, TIOSCC_CAP_PIN, TIOSCC_CAP_CH4} tioscc_mode_t;
endpackage : tioscc_pkg

/* File: rtl/tioscc_unit.sv */
`timescale 1ns/1ps
// one I/O control unit: decodes a field, drives its pin, captures the counter
module tioscc_unit
	import tioscc_pkg::*;
#(
	parameter int W          = tioscc_pkg::CNT_W,
	parameter bit CH4_SOURCE = 1'b0
)
(
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	input  wire logic [tioscc_pkg::FIELD_W-1:0] field,
	input  wire logic                          inhibit,
	input  wire logic                          compare_match,
	input  wire logic                          pin_in,
	input  wire logic                          ch4_count_event,
	input  wire logic [W-1:0]                  counter,
	output logic                               pin_out,
	output logic                               pin_oe_n,
	output logic [W-1:0]                       general_reg,
	output logic                               capture_event
);
	// ****************************************
	// field decode
	// ****************************************
	wire logic       cap_sel   = field[BIT_CAPTURE];
	wire logic       lvl_src   = field[BIT_LEVEL_SRC];
	wire logic [1:0] action    = {field[BIT_ACT_HI], field[BIT_ACT_LO]};
	tioscc_mode_t    mode;
	always_comb
	begin
		if (inhibit)
			mode = TIOSCC_CMP_OFF;
		else if (!cap_sel && action == ACT_NONE)
			mode = TIOSCC_CMP_OFF;
		else if (!cap_sel)
			mode = TIOSCC_CMP_OUT;
		else if (CH4_SOURCE && lvl_src)
			mode = TIOSCC_CAP_CH4;
		else
			mode = TIOSCC_CAP_PIN;
	end

	// ****************************************
	// pin edge detection
	// ****************************************
	logic pin_prev_reg;
	wire logic rise_w = pin_in && !pin_prev_reg;
	wire logic fall_w = !pin_in && pin_prev_reg;
	wire logic pin_edge_w = action[1] ? (rise_w || fall_w)
	                       : (action[0] ? fall_w : rise_w);
	wire logic cap_w = (mode == TIOSCC_CAP_PIN && pin_edge_w) ||
	                   (mode == TIOSCC_CAP_CH4 && ch4_count_event);

	// ****************************************
	// compare output level
	// ****************************************
	logic pin_out_next;
	logic mode_out_prev_reg;
	wire logic entering_w = (mode == TIOSCC_CMP_OUT) && !mode_out_prev_reg;
	always_comb
	begin
		pin_out_next = pin_out;
		if (entering_w)
			pin_out_next = lvl_src;
		else if (mode == TIOSCC_CMP_OUT && compare_match)
		begin
			unique case (action)
				ACT_DRIVE0: pin_out_next = 1'b0;
				ACT_DRIVE1: pin_out_next = 1'b1;
				ACT_TOGGLE: pin_out_next = !pin_out;
				ACT_NONE:   pin_out_next = pin_out;
			endcase
		end
	end

	// registers; capture takes the counter as it stands when the edge is seen
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pin_prev_reg      <= 1'b0;
			mode_out_prev_reg <= 1'b0;
			pin_out           <= 1'b0;
			pin_oe_n          <= 1'b1;
			general_reg       <= '0;
			capture_event     <= 1'b0;
		end
		else
		begin
			pin_prev_reg      <= pin_in;
			mode_out_prev_reg <= (mode == TIOSCC_CMP_OUT);
			pin_out           <= pin_out_next;
			pin_oe_n          <= (mode != TIOSCC_CMP_OUT);
			capture_event     <= cap_w;
			if (cap_w)
				general_reg <= counter;
		end
	end
endmodule : tioscc_unit

/* File: bench/tioscc_pin_model.sv */
`timescale 1ns/1ps
// ****
// far-side pin levels
// ****
module tioscc_pin_model
(
	input wire logic       clk,
	input wire logic [2:0] level_req,
	input wire logic [2:0] pin_out,
	input wire logic [2:0] pin_oe_n,
	output logic     [2:0] pin_in
);
	// registered so a level never races the block's sampling edge;
	// an enable not yet low (unknown before reset) counts as released, so no false edge
	always @(posedge clk)
	begin
		for (int i = 0; i < 3; i++)
			pin_in[i] <= (pin_oe_n[i] !== 1'b0) ? level_req[i] : pin_out[i];
	end
endmodule : tioscc_pin_model

/* File: bench/tioscc_assertions.sv */
`timescale 1ns/1ps
// ****
// port checks
// ****
module tioscc_assertions
	import tioscc_pkg::*;
#(
	parameter int W = tioscc_pkg::CNT_W
)
(
	input wire logic                            clk,
	input wire logic                            rst_n,
	input wire logic [tioscc_pkg::FIELD_W-1:0] chan2_a_field,
	input wire logic [tioscc_pkg::FIELD_W-1:0] chan3_a_field,
	input wire logic [tioscc_pkg::FIELD_W-1:0] chan3_c_field,
	input wire logic                            buffer_a_enable,
	input wire logic                            chan2_match_a,
	input wire logic                            chan3_match_a,
	input wire logic                            chan3_match_c,
	input wire logic                            chan2_pin_a_in,
	input wire logic                            chan3_pin_a_in,
	input wire logic                            chan3_pin_c_in,
	input wire logic                            chan4_count_up,
	input wire logic                            chan4_count_down,
	input wire logic [W-1:0]                    chan2_counter,
	input wire logic [W-1:0]                    chan3_counter,
	input wire logic                            chan2_pin_a_out,
	input wire logic                            chan2_pin_a_oe_n,
	input wire logic                            chan3_pin_a_out,
	input wire logic                            chan3_pin_c_out,
	input wire logic                            chan3_pin_c_oe_n,
	input wire logic [W-1:0]                    chan2_general_reg_a,
	input wire logic [W-1:0]                    chan3_general_reg_a,
	input wire logic [W-1:0]                    chan3_general_reg_c,
	input wire logic [NUM_UNITS-1:0]            capture_pulse
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// captures land one edge later with the counter of the sampling edge
	rise_capture_a: assert property (
		chan2_a_field ==? 4'b1?00 && $rose(chan2_pin_a_in)
		|=> capture_pulse[0] && chan2_general_reg_a == $past(chan2_counter)) else $error("ch2 rise capture");
	fall_capture_a: assert property (
		chan3_a_field == 4'h9 && $fell(chan3_pin_a_in)
		|=> capture_pulse[1] && chan3_general_reg_a == $past(chan3_counter)) else $error("ch3 fall capture");
	both_edge_a: assert property (
		!buffer_a_enable && chan3_c_field ==? 4'b101? && $changed(chan3_pin_c_in)
		|=> capture_pulse[2] && chan3_general_reg_c == $past(chan3_counter)) else $error("ch3 c capture");
	ch4_source_a: assert property (
		chan3_a_field[3:2] == 2'h3 && (chan4_count_up || chan4_count_down)
		|=> capture_pulse[1] && chan3_general_reg_a == $past(chan3_counter)) else $error("ch4 capture");
	buffer_quiet_a: assert property (
		buffer_a_enable |=> !capture_pulse[2] && chan3_pin_c_oe_n && $stable(chan3_general_reg_c))
		else $error("c active in buffer mode");
	// the entry edge ignores matches, so only a settled field is judged
	drive_low_a: assert property (
		$past(rst_n) && $stable(chan2_a_field) && chan2_a_field ==? 4'b0?01 && chan2_match_a
		|=> !chan2_pin_a_out && !chan2_pin_a_oe_n) else $error("drive 0 missed");
	drive_high_a: assert property (
		$past(rst_n) && $stable(chan3_a_field) && chan3_a_field ==? 4'b0?10 && chan3_match_a
		|=> chan3_pin_a_out) else $error("drive 1 missed");
	// a settled toggle field with buffer mode off flips the C pin on each match
	toggle_c_a: assert property (
		$past(rst_n) && $stable(chan3_c_field) && $stable(buffer_a_enable) && !buffer_a_enable
		&& chan3_c_field ==? 4'b0?11 && chan3_match_c
		|=> chan3_pin_c_out != $past(chan3_pin_c_out)) else $error("toggle missed");
	output_off_a: assert property (
		chan2_a_field ==? 4'b0?00 || chan2_a_field[3] |=> chan2_pin_a_oe_n) else $error("pin driven");
endmodule : tioscc_assertions

/* File: bench/timer_io_select_ch2_ch3_tb.sv */
`timescale 1ns/1ps
// ****
// pin selector bench
// ****
module timer_io_select_ch2_ch3_tb;
	import tioscc_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, buf_en = 1'b0, up = 1'b0, dn = 1'b0;
	logic [3:0]  f2 = 4'h0, f3a = 4'h0, f3c = 4'h0;
	logic [2:0]  mt = 3'h0, lvl = 3'h0, pin, oe_n, po, cp;
	logic [15:0] c2 = 16'h0, c3 = 16'h0, r2, r3a, r3c;
	int          fail_count = 0, total_checks = 0;
	always #50 clk = ~clk;
	tioscc_pin_model i_pins (.clk(clk), .level_req(lvl), .pin_out(po), .pin_oe_n(oe_n), .pin_in(pin));
	tioscc_top i_dut (.clk(clk), .rst_n(rst_n), .chan2_a_field(f2), .chan3_a_field(f3a), .chan3_c_field(f3c),
		.buffer_a_enable(buf_en), .chan2_match_a(mt[0]), .chan3_match_a(mt[1]), .chan3_match_c(mt[2]),
		.chan2_pin_a_in(pin[0]), .chan3_pin_a_in(pin[1]), .chan3_pin_c_in(pin[2]), .chan4_count_up(up),
		.chan4_count_down(dn), .chan2_counter(c2), .chan3_counter(c3), .chan2_pin_a_out(po[0]),
		.chan2_pin_a_oe_n(oe_n[0]), .chan3_pin_a_out(po[1]), .chan3_pin_a_oe_n(oe_n[1]),
		.chan3_pin_c_out(po[2]), .chan3_pin_c_oe_n(oe_n[2]), .chan2_general_reg_a(r2),
		.chan3_general_reg_a(r3a), .chan3_general_reg_c(r3c), .capture_pulse(cp));
	// inputs move 10 ns after the edge so sampling never races
	task automatic step(int n = 1);
		repeat (n) @(posedge clk);
		#10;
	endtask : step
	task automatic chk(logic [15:0] seen, logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic t_reset();
		chk({10'h0, oe_n, cp}, 16'h38);
		chk(r2 | r3a | r3c, 16'h0);
		$display("reset test done");
	endtask : t_reset
	// pins reach the block one edge after the request
	task automatic t_capture();
		f2 = 4'hC;
		f3a = 4'h9;
		f3c = 4'hA;
		c2 = 16'h1234;
		c3 = 16'h5678;
		lvl = 3'h7;
		step(2);
		chk({13'h0, cp}, 16'h5);
		chk(r2, 16'h1234);
		c3 = 16'h9ABC;
		lvl = 3'h3;
		step(2);
		chk({13'h0, cp}, 16'h4);
		chk(r3c, 16'h9ABC);
		c3 = 16'h2468;
		lvl = 3'h0;
		step(2);
		chk({13'h0, cp}, 16'h2);
		chk(r3a, 16'h2468);
		$display("capture test done");
	endtask : t_capture
	task automatic t_ch4();
		f3a = 4'hC;
		f3c = 4'hF;
		c3 = 16'h0F0F;
		up = 1'b1;
		step();
		up = 1'b0;
		chk({13'h0, cp}, 16'h6);
		c3 = 16'hF0F0;
		dn = 1'b1;
		step();
		dn = 1'b0;
		chk(r3c, 16'hF0F0);
		$display("channel 4 test done");
	endtask : t_ch4
	task automatic t_buffer();
		buf_en = 1'b1;
		f3c = 4'hA;
		c3 = 16'h7777;
		lvl = 3'h4;
		step(2);
		chk({13'h0, cp}, 16'h0);
		chk(r3c, 16'hF0F0);
		lvl = 3'h0;
		step(2);
		buf_en = 1'b0;
		$display("buffer test done");
	endtask : t_buffer
	task automatic t_compare();
		f2 = 4'h5;
		f3a = 4'h2;
		f3c = 4'h7;
		step(2);
		chk({10'h0, po, oe_n}, 16'h28);
		mt = 3'h7;
		step();
		chk({13'h0, po}, 16'h2);
		mt = 3'h4;
		step();
		mt = 3'h0;
		chk({13'h0, po}, 16'h6);
		f2 = 4'h4;
		f3a = 4'h0;
		step();
		chk({13'h0, oe_n}, 16'h3);
		$display("compare test done");
	endtask : t_compare
	initial
	begin
		step(2);
		rst_n = 1'b1;
		t_reset();
		t_capture();
		t_ch4();
		t_buffer();
		t_compare();
		tally_and_finish();
	end
	// a hung run is cut off well past the expected 19 cycles
	initial
	begin
		#100000;
		fail_count++;
		tally_and_finish();
	end
endmodule : timer_io_select_ch2_ch3_tb
bind tioscc_top tioscc_assertions #(.W(W)) i_chk (.*);
